// ---- hw/resonance_period_report.sv ----
// Resonance period readout registers and drive configuration register
// Operation
// - Period value updates continuously from measurements while the actuator is driven.
// - Upper two bits at high register 1-0, lower eight at low register; reset zero.
// - Reading high freezes both registers until the low register is read.
// - Waveform end releases a pending freeze; updating resumes on next playback.
// - One count equals 24.39 nanoseconds of actuator period.
// - Readings during braking are not guaranteed; braking samples are discarded.
// - Averaging enabled reports mean of last four periods, history starting zero.
// - Averaging-disable bit 6, reset one, reports only the latest period.
// - Config bit 7, reset zero, enables broadcast addressing on the bus.
// - Bits 5-4, reset zero, select supply compensation factor.
`timescale 1ns/1ps
module resonance_period_report
  import period_report_pkg::*;
(
  input  wire logic       CLK,
  input  wire logic       RESET_N,
  input  wire reg_req_t   REG_REQ,
  input  wire meas_t      MEAS,
  input  wire logic       DRIVING,
  input  wire logic       BRAKING,
  input  wire logic       WAVEFORM_DONE,
  output logic      [7:0] REG_RDATA,
  output logic            REG_RVALID,
  output logic            BROADCAST_EN,
  output logic      [1:0] SUPPLY_COMP_SELECT,
  output logic      [1:0] TRIGGER_PIN_FUNCTION,
  output logic      [1:0] OPERATING_MODE,
  output logic            PERIOD_FROZEN
);

  cfg_t                  cfg;
  logic [RESERVED_W-1:0] reserved_high;
  logic [PERIOD_W-1:0]   reported;
  logic [HIGH_W-1:0]     high_copy;
  logic [LOW_W-1:0]      low_copy;
  logic                  frozen;
  logic                  accept;
  logic                  rd_high;
  logic                  rd_low;
  logic                  rd_cfg;
  logic                  wr_high;
  logic                  wr_cfg;
  logic [7:0]            next_rdata;

  // Strobe decode from the serial front end
  assign rd_high = REG_REQ.read && addr_hit(REG_REQ.addr, ADDR_PERIOD_HIGH);
  assign rd_low  = REG_REQ.read && addr_hit(REG_REQ.addr, ADDR_PERIOD_LOW);
  assign rd_cfg  = REG_REQ.read && addr_hit(REG_REQ.addr, ADDR_DRIVE_CFG);
  assign wr_high = REG_REQ.write && addr_hit(REG_REQ.addr, ADDR_PERIOD_HIGH);
  assign wr_cfg  = REG_REQ.write && addr_hit(REG_REQ.addr, ADDR_DRIVE_CFG);

  // Braking samples are dropped; their accuracy is not trusted
  assign accept = MEAS.valid && DRIVING && !BRAKING;

  // Averaging keeps running regardless of the readout lock
  period_history u_history (
    .clk         (CLK),
    .reset_n     (RESET_N),
    .accept      (accept),
    .sample      (MEAS.period),
    .avg_disable (cfg.period_averaging_disable),
    .reported    (reported)
  );

  // Read-order lock over the visible halves
  period_snapshot u_snapshot (
    .clk       (CLK),
    .reset_n   (RESET_N),
    .live      (reported),
    .read_high (rd_high),
    .read_low  (rd_low),
    .wave_done (WAVEFORM_DONE),
    .high_copy (high_copy),
    .low_copy  (low_copy),
    .frozen    (frozen)
  );

  // Configuration register; fields drive the rest of the device
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      cfg <= CFG_RESET;
    end else if (wr_cfg) begin
      cfg <= cfg_t'(REG_REQ.wdata);
    end
  end

  // Reserved high bits are storage only, kept apart from the period
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      reserved_high <= RESERVED_RESET;
    end else if (wr_high) begin
      reserved_high <= REG_REQ.wdata[LOW_W-1:HIGH_W];
    end
  end

  // Readback mux; raw counts, host scales by the period step
  assign next_rdata = rd_high ? {reserved_high, high_copy} :
                      rd_low  ? low_copy :
                      rd_cfg  ? 8'(cfg) :
                      UNMAPPED_DATA;

  // Read answer lands one edge after the strobe
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      REG_RDATA  <= RDATA_RESET;
      REG_RVALID <= 1'b0;
    end else begin
      REG_RDATA  <= REG_REQ.read ? next_rdata : REG_RDATA;
      REG_RVALID <= REG_REQ.read;
    end
  end

  // Config outputs are mirrored flops so they never glitch on writes
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      BROADCAST_EN         <= CFG_RESET.broadcast_enable;
      SUPPLY_COMP_SELECT   <= CFG_RESET.supply_comp_select;
      TRIGGER_PIN_FUNCTION <= CFG_RESET.trigger_pin_function;
      OPERATING_MODE       <= CFG_RESET.operating_mode;
      PERIOD_FROZEN        <= 1'b0;
    end else begin
      BROADCAST_EN         <= cfg.broadcast_enable;
      SUPPLY_COMP_SELECT   <= cfg.supply_comp_select;
      TRIGGER_PIN_FUNCTION <= cfg.trigger_pin_function;
      OPERATING_MODE       <= cfg.operating_mode;
      PERIOD_FROZEN        <= frozen;
    end
  end

  // Checks on the block's own behaviour
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RESET_N);

  sequence s_high_read;
    rd_high && !frozen;
  endsequence

  sequence s_held_quiet;
    !rd_low && !WAVEFORM_DONE;
  endsequence

  a_freeze_on_high: assert property (
    s_high_read ##1 s_held_quiet |=> frozen && $stable(high_copy) && $stable(low_copy))
    else $error("Copies moved or lock dropped after high read");

  a_lock_holds_copies: assert property (
    frozen && !rd_low && !WAVEFORM_DONE |=> frozen && $stable({high_copy, low_copy}))
    else $error("Frozen copies changed before low read");

  a_low_releases: assert property (
    frozen && rd_low && !rd_high |=> !frozen ##1 ({high_copy, low_copy} == $past(reported)))
    else $error("Low read did not release and reload");

  a_wave_end_release: assert property (
    frozen && WAVEFORM_DONE && !rd_high && !rd_low |=> !frozen)
    else $error("Waveform end did not release lock");

  a_copies_reload: assert property (
    !frozen && !rd_high |=> {high_copy, low_copy} == $past(reported))
    else $error("Open copies did not follow reported value");

  a_read_answer: assert property (
    rd_high |=> REG_RVALID && REG_RDATA == {$past(reserved_high), $past(high_copy)})
    else $error("High read returned wrong data");

  a_low_answer: assert property (
    rd_low |=> REG_RVALID && REG_RDATA == $past(low_copy))
    else $error("Low read returned wrong data");

  a_latest_only: assert property (
    cfg.period_averaging_disable && accept ##1 (cfg.period_averaging_disable && !wr_cfg)
    |=> reported == $past(MEAS.period, 2))
    else $error("Latest period not reported with averaging off");

  a_braking_ignored: assert property (
    BRAKING && !wr_cfg |=> ##1 $stable(reported))
    else $error("Period moved while braking");

  a_cfg_write: assert property (
    wr_cfg |=> ##1 BROADCAST_EN == $past(REG_REQ.wdata[7], 2)
      && SUPPLY_COMP_SELECT == $past(REG_REQ.wdata[5:4], 2))
    else $error("Config write not reflected on outputs");

  a_reserved_apart: assert property (
    wr_high && !frozen && !rd_high |=> {high_copy, low_copy} == $past(reported))
    else $error("Reserved write disturbed the period copies");

  // Read port timing: one answer per strobe, data held between reads
  a_rvalid_timing: assert property (
    1'b1 |=> REG_RVALID == $past(REG_REQ.read))
    else $error("Read answer not one cycle after strobe");

  a_rdata_holds: assert property (
    !REG_REQ.read |=> $stable(REG_RDATA))
    else $error("Read data moved without a read");

  a_cfg_answer: assert property (
    rd_cfg |=> REG_RVALID && cfg_t'(REG_RDATA) == $past(cfg))
    else $error("Config read returned wrong data");

  // Write side: low half read-only, reserved bits stored apart
  a_low_read_only: assert property (
    REG_REQ.write && addr_hit(REG_REQ.addr, ADDR_PERIOD_LOW)
    |=> $stable(cfg) && $stable(reserved_high))
    else $error("Write to low half changed stored state");

  a_reserved_store: assert property (
    wr_high |=> reserved_high == $past(REG_REQ.wdata[LOW_W-1:HIGH_W]))
    else $error("Reserved bits not stored on write");

  a_reserved_quiet: assert property (
    !wr_high |=> $stable(reserved_high))
    else $error("Reserved bits changed without a write");

  a_cfg_holds: assert property (
    !wr_cfg |=> $stable(cfg))
    else $error("Config changed without a write");

  // Output flops mirror their sources one cycle late
  a_cfg_mirror: assert property (
    1'b1 |=> BROADCAST_EN == $past(cfg.broadcast_enable)
      && SUPPLY_COMP_SELECT == $past(cfg.supply_comp_select)
      && TRIGGER_PIN_FUNCTION == $past(cfg.trigger_pin_function)
      && OPERATING_MODE == $past(cfg.operating_mode))
    else $error("Config outputs do not mirror the register");

  a_frozen_mirror: assert property (
    1'b1 |=> PERIOD_FROZEN == $past(frozen))
    else $error("Frozen flag does not mirror the lock");

  // Lock transitions; a repeated high read must keep the lock
  a_high_read_locks: assert property (
    rd_high |=> frozen)
    else $error("High read did not leave the lock held");

  a_open_stays_open: assert property (
    !frozen && !rd_high |=> !frozen)
    else $error("Lock taken without a high read");

  // Release by waveform end, then reload unless a new high read blocks it
  sequence s_wave_release;
    frozen && WAVEFORM_DONE && !rd_high;
  endsequence

  a_wave_reload: assert property (
    s_wave_release ##1 !rd_high
    |=> {high_copy, low_copy} == $past(reported))
    else $error("Copies not reloaded after waveform end");

  // Measurement keeps running behind the lock and stops outside playback
  a_runs_while_frozen: assert property (
    frozen && accept && cfg.period_averaging_disable ##1 cfg.period_averaging_disable
    |=> reported == $past(MEAS.period, 2))
    else $error("Measurement stalled while copies frozen");

  a_idle_dropped: assert property (
    !DRIVING && !wr_cfg |=> ##1 $stable(reported))
    else $error("Period moved while not driving");

endmodule

// ---- pkg/period_report_pkg.sv ----
// Shared constants, carriers and helpers for the resonance period readout block
package period_report_pkg;

  // Register offsets as seen by the serial register port
  localparam logic [7:0] ADDR_PERIOD_HIGH = 8'h05;
  localparam logic [7:0] ADDR_PERIOD_LOW  = 8'h06;
  localparam logic [7:0] ADDR_DRIVE_CFG   = 8'h07;

  // Widths and field positions
  localparam int PERIOD_W      = 10;
  localparam int HIGH_W        = 2;
  localparam int LOW_W         = 8;
  localparam int RESERVED_W    = 6;
  localparam int HIGH_LSB      = 8;
  localparam int HISTORY_DEPTH = 4;
  localparam int SUM_W         = 12;
  localparam int AVG_SHIFT     = 2;

  // One period count in picoseconds; the readout is raw counts of this step
  localparam int PERIOD_STEP_PS = 24390;

  // Reset values and the answer to unmapped reads
  localparam logic [PERIOD_W-1:0]   PERIOD_RESET   = 10'h000;
  localparam logic [RESERVED_W-1:0] RESERVED_RESET = 6'h00;
  localparam logic [LOW_W-1:0]      RDATA_RESET    = 8'h00;
  localparam logic [LOW_W-1:0]      UNMAPPED_DATA  = 8'h00;

  // Drive configuration register, bit 7 down to bit 0
  typedef struct packed {
    logic       broadcast_enable;
    logic       period_averaging_disable;
    logic [1:0] supply_comp_select;
    logic [1:0] trigger_pin_function;
    logic [1:0] operating_mode;
  } cfg_t;

  localparam cfg_t CFG_RESET = '{
    broadcast_enable:         1'h0,
    period_averaging_disable: 1'h1,
    supply_comp_select:       2'h0,
    trigger_pin_function:     2'h1,
    operating_mode:           2'h0
  };

  // One decoded register access from the serial front end
  typedef struct packed {
    logic       read;
    logic       write;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

  // One measured period from the resonance tracker
  typedef struct packed {
    logic                valid;
    logic [PERIOD_W-1:0] period;
  } meas_t;

  // Readout lock, Gray coded
  typedef enum logic [0:0] {
    LOCK_OPEN = 1'b0,
    LOCK_HELD = 1'b1
  } lock_state_t;

  // Address match used by every strobe decode
  function automatic logic addr_hit(input logic [7:0] addr, input logic [7:0] target);
    return addr == target;
  endfunction

endpackage

// ---- hw/period_history.sv ----
// Four-deep period history with mean or latest selection
`timescale 1ns/1ps
module period_history
  import period_report_pkg::*;
(
  input  wire logic                clk,
  input  wire logic                reset_n,
  input  wire logic                accept,
  input  wire logic [PERIOD_W-1:0] sample,
  input  wire logic                avg_disable,
  output logic      [PERIOD_W-1:0] reported
);

  logic [PERIOD_W-1:0] history [HISTORY_DEPTH];
  logic [SUM_W-1:0]    sum;
  logic [PERIOD_W-1:0] mean;
  logic [PERIOD_W-1:0] next_reported;

  // Sum of all entries; empty slots count as zero until filled
  always_comb begin
    sum = '0;
    for (int i = 0; i < HISTORY_DEPTH; i++) begin
      sum = sum + SUM_W'(history[i]);
    end
  end

  assign mean          = sum[AVG_SHIFT +: PERIOD_W];
  assign next_reported = avg_disable ? history[0] : mean;

  // Shift in a new period on each accepted measurement
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      for (int i = 0; i < HISTORY_DEPTH; i++) begin
        history[i] <= PERIOD_RESET;
      end
    end else if (accept) begin
      history[0] <= sample;
      for (int i = 1; i < HISTORY_DEPTH; i++) begin
        history[i] <= history[i-1];
      end
    end
  end

  // Registered result keeps the adder off the readout path
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      reported <= PERIOD_RESET;
    end else begin
      reported <= next_reported;
    end
  end

  // Averaged readout is the floor of the four-entry mean
  a_mean_of_four: assert property (
    @(posedge clk) disable iff (!reset_n)
    !avg_disable |=> reported == $past(PERIOD_W'((SUM_W'(history[0]) + SUM_W'(history[1])
      + SUM_W'(history[2]) + SUM_W'(history[3])) >> AVG_SHIFT)))
    else $error("Averaged period is not the mean of four");

endmodule

// ---- hw/period_snapshot.sv ----
// Host-visible period copies with read-order freeze
`timescale 1ns/1ps
module period_snapshot
  import period_report_pkg::*;
(
  input  wire logic                clk,
  input  wire logic                reset_n,
  input  wire logic [PERIOD_W-1:0] live,
  input  wire logic                read_high,
  input  wire logic                read_low,
  input  wire logic                wave_done,
  output logic      [HIGH_W-1:0]   high_copy,
  output logic      [LOW_W-1:0]    low_copy,
  output logic                     frozen
);

  lock_state_t state;
  lock_state_t next_state;
  logic        load;

  // Set by a high read wins over any release in the same cycle
  always_comb begin
    next_state = state;
    unique case (state)
      LOCK_OPEN: begin
        if (read_high) begin
          next_state = LOCK_HELD;
        end
      end
      LOCK_HELD: begin
        if (read_high) begin
          next_state = LOCK_HELD;
        end else if (read_low || wave_done) begin
          next_state = LOCK_OPEN;
        end
      end
    endcase
  end

  // Copies must not move on the edge that returns the high half
  assign load = (state == LOCK_OPEN) && !read_high;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state <= LOCK_OPEN;
    end else begin
      state <= next_state;
    end
  end

  // Copies track the live value only while open
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      high_copy <= PERIOD_RESET[HIGH_LSB +: HIGH_W];
      low_copy  <= PERIOD_RESET[LOW_W-1:0];
    end else if (load) begin
      high_copy <= live[HIGH_LSB +: HIGH_W];
      low_copy  <= live[LOW_W-1:0];
    end
  end

  assign frozen = (state == LOCK_HELD);

endmodule

// ---- verification/host_model.sv ----
// Host side register access model, single and paired accesses
`timescale 1ns/1ps
module host_model
  import period_report_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       reset_n,
  input  wire logic       go_rd,
  input  wire logic       go_wr,
  input  wire logic       go_pair,
  input  wire logic [7:0] go_addr,
  input  wire logic [7:0] go_data,
  output reg_req_t        req
);
  logic pend;
  // Pair reads high then low back to back; idle lines invert so no stale value lingers
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      req  <= '0;
      pend <= 1'b0;
    end else begin
      req.read  <= go_rd | go_pair | pend;
      req.write <= go_wr;
      req.addr  <= pend ? ADDR_PERIOD_LOW : go_pair ? ADDR_PERIOD_HIGH
                 : (go_rd | go_wr) ? go_addr : ~req.addr;
      req.wdata <= go_wr ? go_data : ~req.wdata;
      pend      <= go_pair;
    end
  end
endmodule

// ---- verification/testbench.sv ----
// Self-checking bench for the resonance period readout block
`timescale 1ns/1ps
module testbench;
  import period_report_pkg::*;
  logic                CLK = 1'b0;
  logic                RESET_N = 1'b0;
  meas_t               MEAS = '0;
  logic                DRIVING = 1'b1;
  logic                BRAKING = 1'b0;
  logic                WAVEFORM_DONE = 1'b0;
  logic                go_rd = 1'b0;
  logic                go_wr = 1'b0;
  logic                go_pair = 1'b0;
  logic [7:0]          go_addr = 8'h00;
  logic [7:0]          go_data = 8'h00;
  reg_req_t            req;
  logic [7:0]          rdata;
  logic                rvalid;
  logic                bcast;
  logic                frozen;
  logic [1:0]          comp;
  logic [1:0]          trig;
  logic [1:0]          mode;
  logic [7:0]          expq[$];
  logic [PERIOD_W-1:0] hist[HISTORY_DEPTH];
  logic [15:0]         seed = 16'h1048;
  logic [5:0]          resv = 6'h00;
  logic                avg_on = 1'b0;
  int                  fails = 0;
  int                  n_compared = 0;

  // Clock at 200 MHz
  always #2.5 CLK = ~CLK;

  host_model u_host (.clk(CLK), .reset_n(RESET_N), .go_rd(go_rd), .go_wr(go_wr),
    .go_pair(go_pair), .go_addr(go_addr), .go_data(go_data), .req(req));

  resonance_period_report u_dut (.CLK(CLK), .RESET_N(RESET_N), .REG_REQ(req), .MEAS(MEAS),
    .DRIVING(DRIVING), .BRAKING(BRAKING), .WAVEFORM_DONE(WAVEFORM_DONE), .REG_RDATA(rdata),
    .REG_RVALID(rvalid), .BROADCAST_EN(bcast), .SUPPLY_COMP_SELECT(comp),
    .TRIGGER_PIN_FUNCTION(trig), .OPERATING_MODE(mode), .PERIOD_FROZEN(frozen));

  task automatic conclude();
    $display("compared %0d, failed %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic fail(input string m);
    fails++;
    $display("[FAIL] %0t %s", $time, m);
  endtask

  task automatic cmp_rd(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) fail($sformatf("read data %h, expected %h", got, exp));
  endtask

  task automatic cmp_out(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) fail($sformatf("output level %h, expected %h", got, exp));
  endtask

  // Monitor takes the oldest note whenever an answer appears
  always @(posedge CLK) begin
    if (rvalid === 1'b1) begin
      if (expq.size() == 0) fail("read answer without request");
      else cmp_rd(rdata, expq.pop_front());
    end
  end

  function automatic void get(output logic [PERIOD_W-1:0] v);
    seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
    v = seed[9:0];
  endfunction

  function automatic logic [PERIOD_W-1:0] rep();
    logic [SUM_W-1:0] s;
    s = hist[0] + hist[1] + hist[2] + hist[3];
    return avg_on ? PERIOD_W'(s >> AVG_SHIFT) : hist[0];
  endfunction

  task automatic idle(input int n);
    repeat (n) @(posedge CLK);
  endtask

  // Requests go to the host model, which puts them on the port one edge later
  task automatic acc(input logic r, input logic w, input logic p, input logic [7:0] a,
                     input logic [7:0] d);
    go_rd   <= r;
    go_wr   <= w;
    go_pair <= p;
    go_addr <= a;
    go_data <= d;
    @(posedge CLK);
    go_rd   <= 1'b0;
    go_wr   <= 1'b0;
    go_pair <= 1'b0;
    @(posedge CLK);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    expq.push_back(e);
    acc(1'b1, 1'b0, 1'b0, a, 8'h00);
  endtask

  task automatic pair(input logic [PERIOD_W-1:0] v);
    expq.push_back({resv, v[9:8]});
    expq.push_back(v[7:0]);
    acc(1'b0, 1'b0, 1'b1, 8'h00, 8'h00);
  endtask

  // Samples count only while driving and not braking
  task automatic sample(input logic [PERIOD_W-1:0] p);
    MEAS <= '{valid: 1'b1, period: p};
    @(posedge CLK);
    MEAS.valid <= 1'b0;
    if (DRIVING && !BRAKING) begin
      for (int i = HISTORY_DEPTH - 1; i > 0; i--) hist[i] = hist[i-1];
      hist[0] = p;
    end
    idle(5);
  endtask

  initial begin
    #40000;
    fail("run limit reached");
    conclude();
  end

  initial begin
    logic [PERIOD_W-1:0] v;
    logic [PERIOD_W-1:0] w;
    logic [PERIOD_W-1:0] x;
    logic [7:0]          d;
    for (int i = 0; i < HISTORY_DEPTH; i++) hist[i] = '0;
    repeat (4) @(posedge CLK);
    RESET_N <= 1'b1;
    @(posedge CLK);
    // Reset values
    rd(ADDR_PERIOD_HIGH, 8'h00);
    rd(ADDR_PERIOD_LOW, 8'h00);
    rd(ADDR_DRIVE_CFG, 8'h44);
    cmp_out({bcast, frozen, comp, trig, mode}, 8'h04);
    // Latest period, split across the two registers
    get(v);
    sample(v);
    pair(v);
    // High read freezes copies while measurement runs on
    rd(ADDR_PERIOD_HIGH, {resv, v[9:8]});
    idle(3);
    cmp_out({7'h00, frozen}, 8'h01);
    get(w);
    sample(w);
    rd(ADDR_PERIOD_HIGH, {resv, v[9:8]});
    rd(ADDR_PERIOD_LOW, v[7:0]);
    idle(3);
    pair(w);
    // Braking and idle samples are dropped
    BRAKING <= 1'b1;
    get(x);
    sample(x);
    BRAKING <= 1'b0;
    DRIVING <= 1'b0;
    get(x);
    sample(x);
    DRIVING <= 1'b1;
    pair(w);
    // Waveform end releases a pending freeze
    rd(ADDR_PERIOD_HIGH, {resv, w[9:8]});
    get(x);
    sample(x);
    WAVEFORM_DONE <= 1'b1;
    @(posedge CLK);
    WAVEFORM_DONE <= 1'b0;
    idle(4);
    cmp_out({7'h00, frozen}, 8'h00);
    rd(ADDR_PERIOD_LOW, x[7:0]);
    // Reserved storage, read-only low half, unmapped place
    acc(1'b0, 1'b1, 1'b0, ADDR_PERIOD_HIGH, 8'hFF);
    resv = 6'h3F;
    acc(1'b0, 1'b1, 1'b0, ADDR_PERIOD_LOW, 8'h00);
    rd(8'h20, UNMAPPED_DATA);
    pair(x);
    // Every compensation code, fields reach the outputs
    for (int k = 0; k < 4; k++) begin
      get(v);
      d = {v[7], 1'b1, 2'(k), v[3:0]};
      acc(1'b0, 1'b1, 1'b0, ADDR_DRIVE_CFG, d);
      idle(2);
      cmp_out({bcast, 1'b0, comp, trig, mode}, {d[7], 1'b0, d[5:0]});
      rd(ADDR_DRIVE_CFG, d);
    end
    // Mid-run reset brings back every reset value and clears the history
    RESET_N <= 1'b0;
    idle(2);
    RESET_N <= 1'b1;
    for (int i = 0; i < HISTORY_DEPTH; i++) hist[i] = '0;
    resv = 6'h00;
    @(posedge CLK);
    rd(ADDR_DRIVE_CFG, 8'h44);
    cmp_out({bcast, frozen, comp, trig, mode}, 8'h04);
    pair(PERIOD_RESET);
    // Averaging over the last four, history from zero
    acc(1'b0, 1'b1, 1'b0, ADDR_DRIVE_CFG, 8'h04);
    avg_on = 1'b1;
    idle(4);
    pair(rep());
    for (int k = 0; k < 5; k++) begin
      get(v);
      sample(v);
      pair(rep());
    end
    for (int i = 0; i < 20 && expq.size() > 0; i++) @(posedge CLK);
    if (expq.size() > 0) fail("read answer missing");
    conclude();
  end
endmodule
